// [rtl/bcb_pkg.sv]
// package: constants and types of the bit/carry and branch unit
package bcb_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00; // op launch
  localparam logic [7:0] OPND_ADDR   = 8'h04; // register operand byte
  localparam logic [7:0] GPR_ADDR    = 8'h08; // bit index register
  localparam logic [7:0] FLAGS_ADDR  = 8'h0C; // condition flags
  localparam logic [7:0] PC_ADDR     = 8'h10; // program counter
  localparam logic [7:0] TGT_ADDR    = 8'h14; // branch target
  localparam logic [7:0] STAT_ADDR   = 8'h18; // status, read only
  localparam logic [7:0] MDATA_ADDR  = 8'h1C; // memory byte window
  // ------------------------------------------------------------
  // field layout, reset values, sizes
  // ------------------------------------------------------------
  localparam int          CTRL_W     = 17;
  localparam int          FLAGS_W    = 4;
  localparam int          STK_DEPTH  = 8;
  localparam int          MEM_DEPTH  = 8;
  localparam logic [31:0] PC_RST     = 32'h0000_0000;
  localparam logic [31:0] LEN_SHORT  = 32'h0000_0002;
  localparam logic [31:0] LEN_LONG   = 32'h0000_0004;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // ------------------------------------------------------------
  // operation codes (ctrl.op)
  // ------------------------------------------------------------
  localparam logic [3:0] OP_NONE   = 4'h0; // only updates ctrl
  localparam logic [3:0] OP_OR     = 4'h1; // bit_or_into_carry
  localparam logic [3:0] OP_IOR    = 4'h2;
  localparam logic [3:0] OP_XOR    = 4'h3; // bit_xor_into_carry
  localparam logic [3:0] OP_IXOR   = 4'h4;
  localparam logic [3:0] OP_LD     = 4'h5; // bit_load_to_carry
  localparam logic [3:0] OP_ILD    = 4'h6;
  localparam logic [3:0] OP_ST     = 4'h7; // carry_store_to_bit
  localparam logic [3:0] OP_IST    = 4'h8;
  localparam logic [3:0] OP_COND   = 4'h9; // conditional branch
  localparam logic [3:0] OP_JUMP   = 4'hA; // unconditional_jump
  localparam logic [3:0] OP_CALLD  = 4'hB; // call, displacement
  localparam logic [3:0] OP_CALLE  = 4'hC; // call, effective addr
  localparam logic [3:0] OP_RET    = 4'hD; // subroutine return
  // ------------------------------------------------------------
  // condition codes (ctrl.cond)
  // ------------------------------------------------------------
  localparam logic [3:0] CC_ALWAYS = 4'h0;
  localparam logic [3:0] CC_NEVER  = 4'h1;
  localparam logic [3:0] CC_HI     = 4'h2;
  localparam logic [3:0] CC_LS     = 4'h3;
  localparam logic [3:0] CC_CC     = 4'h4;
  localparam logic [3:0] CC_CS     = 4'h5;
  localparam logic [3:0] CC_NE     = 4'h6;
  localparam logic [3:0] CC_EQ     = 4'h7;
  localparam logic [3:0] CC_VC     = 4'h8;
  localparam logic [3:0] CC_VS     = 4'h9;
  localparam logic [3:0] CC_PL     = 4'hA;
  localparam logic [3:0] CC_MI     = 4'hB;
  localparam logic [3:0] CC_GE     = 4'hC;
  localparam logic [3:0] CC_LT     = 4'hD;
  localparam logic [3:0] CC_GT     = 4'hE;
  localparam logic [3:0] CC_LE     = 4'hF;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] maddr;    // memory byte address
    logic       len4;     // instruction is four bytes long
    logic       to_mem;   // operand is the memory byte
    logic       from_reg; // bit index from gpr low bits
    logic [2:0] imm;      // immediate bit index
    logic [3:0] cond;     // branch condition
    logic [3:0] op;       // operation
  } bcb_ctrl_t;
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bcb_flags_t;
  typedef enum logic [1:0] {
    ST_IDLE, ST_MREAD, ST_EXEC, ST_MWRITE
  } bcb_state_t;
endpackage

// [rtl/bcb_unit.sv]
// module: bit/carry operations and branch evaluation with axi4-lite regs
`timescale 1ns/1ns
// Behaviour
// - or: carry becomes carry or bit
// - inverted or: carry or not bit
// - xor: carry becomes carry xor bit
// - inverted xor: carry xor not bit
// - load: bit copied into carry
// - inverted load: not bit into carry
// - store: carry into bit, carry kept
// - inverted store: not carry into bit
// - inverted forms use immediate index only
// - register index uses low three bits
// - branch taken to target, else sequential
// - flag conditions per table
// - signed conditions per table
// - jump loads target unconditionally
// - calls branch and save return point unless the stack is full
// - return resumes after latest open call
module bcb_unit
  import bcb_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // core view
  output logic [31:0]      pc,
  output logic             carry
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bcb_state_t  state_q;            // sequencer
  bcb_ctrl_t   ctrl_q;             // last written control word
  bcb_flags_t  flags_q;            // n z v c
  logic [7:0]  opnd_q;             // register operand byte
  logic [7:0]  gpr_q;              // index register, low byte
  logic [31:0] pc_q;               // program counter
  logic [31:0] tgt_q;              // branch target
  logic [7:0]  tmp_q;              // memory byte in flight
  logic        taken_q;            // last branch went to target or stack top
  logic        stk_err_q;          // stack over/underflow seen
  logic [3:0]  sp_q;               // return stack depth
  logic [31:0] stk_q [STK_DEPTH];  // return points
  logic [7:0]  mem_q [MEM_DEPTH];  // byte operand memory
  // bus handshake flops
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [7:0]  awaddr_q;           // captured write address
  logic [31:0] wdata_q;            // captured write data
  logic [3:0]  wstrb_q;            // captured strobes

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // byte lane merge, used for every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // branch condition table
  function automatic logic cond_true(input logic [3:0] cc,
                                     input bcb_flags_t f);
    logic r;
    r = 1'b0;
    unique case (cc)
      CC_ALWAYS: r = 1'b1;
      CC_NEVER:  r = 1'b0;
      CC_HI:     r = ~(f.c | f.z);
      CC_LS:     r = f.c | f.z;
      CC_CC:     r = ~f.c;
      CC_CS:     r = f.c;
      CC_NE:     r = ~f.z;
      CC_EQ:     r = f.z;
      CC_VC:     r = ~f.v;
      CC_VS:     r = f.v;
      CC_PL:     r = ~f.n;
      CC_MI:     r = f.n;
      CC_GE:     r = ~(f.n ^ f.v);
      CC_LT:     r = f.n ^ f.v;
      CC_GT:     r = ~(f.z | (f.n ^ f.v));
      CC_LE:     r = f.z | (f.n ^ f.v);
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire         idle     = (state_q == ST_IDLE);
  wire         wr_fire  = ~awready_q & ~wready_q & ~bvalid_q;
  // writes while an op is running are refused, never half applied
  wire         wr_do    = wr_fire & idle;
  wire [31:0]  wmerge_d;
  wire         wr_map   = (awaddr_q == CTRL_ADDR)  |
                          (awaddr_q == OPND_ADDR)  |
                          (awaddr_q == GPR_ADDR)   |
                          (awaddr_q == FLAGS_ADDR) |
                          (awaddr_q == PC_ADDR)    |
                          (awaddr_q == TGT_ADDR)   |
                          (awaddr_q == MDATA_ADDR);
  wire         wr_ctrl  = wr_do & (awaddr_q == CTRL_ADDR);
  wire         wr_opnd  = wr_do & (awaddr_q == OPND_ADDR);
  wire         wr_gpr   = wr_do & (awaddr_q == GPR_ADDR);
  wire         wr_flags = wr_do & (awaddr_q == FLAGS_ADDR);
  wire         wr_pc    = wr_do & (awaddr_q == PC_ADDR);
  wire         wr_tgt   = wr_do & (awaddr_q == TGT_ADDR);
  wire         wr_mdata = wr_do & (awaddr_q == MDATA_ADDR);
  wire         ar_fire  = arvalid & arready_q;
  wire         rd_map   = (araddr <= MDATA_ADDR) & (araddr[1:0] == 2'h0);
  logic [31:0] rd_data;

  // read mux, unmapped reads return zero with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (araddr)
      CTRL_ADDR:  rd_data = {15'h0000, ctrl_q};
      OPND_ADDR:  rd_data = {24'h00_0000, opnd_q};
      GPR_ADDR:   rd_data = {24'h00_0000, gpr_q};
      FLAGS_ADDR: rd_data = {28'h000_0000, flags_q};
      PC_ADDR:    rd_data = pc_q;
      TGT_ADDR:   rd_data = tgt_q;
      STAT_ADDR:  rd_data = {24'h00_0000, sp_q, stk_err_q,
                             taken_q, ~idle, 1'b0};
      MDATA_ADDR: rd_data = {24'h00_0000, mem_q[ctrl_q.maddr]};
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // bit operation datapath
  // ------------------------------------------------------------
  wire bcb_ctrl_t ctrl_d = bcb_ctrl_t'(wmerge_d[CTRL_W-1:0]);
  assign wmerge_d = merge({15'h0000, ctrl_q}, wdata_q, wstrb_q);
  wire        op_inv   = (ctrl_q.op == OP_IOR) | (ctrl_q.op == OP_IXOR) |
                         (ctrl_q.op == OP_ILD) | (ctrl_q.op == OP_IST);
  wire        op_store = (ctrl_q.op == OP_ST) | (ctrl_q.op == OP_IST);
  // inverted forms only know the immediate index
  wire [2:0]  bit_idx  = (ctrl_q.from_reg & ~op_inv) ? gpr_q[2:0]
                                                     : ctrl_q.imm;
  wire [7:0]  src_byte = ctrl_q.to_mem ? tmp_q : opnd_q;
  wire        sel_bit  = src_byte[bit_idx];
  wire        eff_bit  = sel_bit ^ op_inv;
  wire        st_bit   = flags_q.c ^ op_inv;
  logic [7:0] st_byte;
  logic       carry_d;

  // only the addressed bit follows the carry, others pass through
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_st
      assign st_byte[gi] = (bit_idx == 3'(gi)) ? st_bit
                                               : src_byte[gi];
    end
  endgenerate

  // new carry per operation; stores keep it
  always_comb begin
    carry_d = flags_q.c;
    unique case (ctrl_q.op)
      OP_OR, OP_IOR:   carry_d = flags_q.c | eff_bit;
      OP_XOR, OP_IXOR: carry_d = flags_q.c ^ eff_bit;
      OP_LD, OP_ILD:   carry_d = eff_bit;
      default:         carry_d = flags_q.c;
    endcase
  end

  // ------------------------------------------------------------
  // branch datapath
  // ------------------------------------------------------------
  wire        is_call  = (ctrl_q.op == OP_CALLD) | (ctrl_q.op == OP_CALLE);
  wire        is_ret   = (ctrl_q.op == OP_RET);
  wire [31:0] seq_pc   = pc_q + (ctrl_q.len4 ? LEN_LONG : LEN_SHORT);
  wire        push_ok  = is_call & (sp_q < 4'(STK_DEPTH));
  wire        pop_ok   = is_ret & (sp_q != 4'h0);
  wire [31:0] stk_top  = stk_q[3'(sp_q - 4'h1)];
  wire        to_tgt   = ((ctrl_q.op == OP_COND) &
                          cond_true(ctrl_q.cond, flags_q)) |
                         (ctrl_q.op == OP_JUMP) | push_ok;
  // a failed push or pop falls through rather than jumping wild
  wire [31:0] pc_d     = pop_ok ? stk_top :
                         to_tgt ? tgt_q : seq_pc;
  wire        is_flow  = (ctrl_q.op >= OP_COND) & (ctrl_q.op <= OP_RET);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // memory operands are fetched first, stores write back last
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (wr_ctrl && ctrl_d.op != OP_NONE) begin
            state_q <= ctrl_d.to_mem ? ST_MREAD : ST_EXEC;
          end
        end
        ST_MREAD: state_q <= ST_EXEC;
        ST_EXEC: begin
          state_q <= (op_store && ctrl_q.to_mem) ? ST_MWRITE
                                                 : ST_IDLE;
        end
        ST_MWRITE: state_q <= ST_IDLE;
      endcase
    end
  end

  // memory byte in flight: fetched, then replaced by merged byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmp_q <= 8'h00;
    end else if (state_q == ST_MREAD) begin
      tmp_q <= mem_q[ctrl_q.maddr];
    end else if (state_q == ST_EXEC && op_store) begin
      tmp_q <= st_byte;
    end
  end

  // bus word merged onto one memory byte, low lane only
  function automatic logic [7:0] wmerge_mem(input logic [7:0] old);
    logic [31:0] m;
    m = merge({24'h00_0000, old}, wdata_q, wstrb_q);
    return m[7:0];
  endfunction

  // operand memory: bus window or store write-back
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (state_q == ST_MWRITE) begin
      mem_q[ctrl_q.maddr] <= tmp_q;
    end else if (wr_mdata) begin
      mem_q[ctrl_q.maddr] <= wmerge_mem(mem_q[ctrl_q.maddr]);
    end
  end

  // control, operand and flag registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q  <= '0;
      opnd_q  <= 8'h00;
      gpr_q   <= 8'h00;
      flags_q <= '0;
      tgt_q   <= 32'h0000_0000;
    end else if (state_q == ST_EXEC) begin
      flags_q.c <= carry_d;
      if (op_store && !ctrl_q.to_mem) begin
        opnd_q <= st_byte;
      end
    end else begin
      if (wr_ctrl)  ctrl_q  <= ctrl_d;
      if (wr_opnd)  opnd_q  <= 8'(merge({24'h0, opnd_q}, wdata_q,
                                        wstrb_q));
      if (wr_gpr)   gpr_q   <= 8'(merge({24'h0, gpr_q}, wdata_q,
                                        wstrb_q));
      if (wr_flags) flags_q <= bcb_flags_t'(4'(merge({28'h0, flags_q},
                                        wdata_q, wstrb_q)));
      if (wr_tgt)   tgt_q   <= merge(tgt_q, wdata_q, wstrb_q);
    end
  end

  // program counter, return stack and branch status
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q      <= PC_RST;
      sp_q      <= 4'h0;
      taken_q   <= 1'b0;
      stk_err_q <= 1'b0;
      for (int i = 0; i < STK_DEPTH; i++) stk_q[i] <= 32'h0000_0000;
    end else if (state_q == ST_EXEC && is_flow) begin
      pc_q    <= pc_d;
      taken_q <= to_tgt | pop_ok;
      if (push_ok) begin
        stk_q[3'(sp_q)] <= seq_pc;
        sp_q            <= sp_q + 4'h1;
      end
      if (pop_ok) sp_q <= sp_q - 4'h1;
      if ((is_call && !push_ok) || (is_ret && !pop_ok)) begin
        stk_err_q <= 1'b1;
      end
    end else if (wr_pc) begin
      pc_q <= merge(pc_q, wdata_q, wstrb_q);
    end
  end

  // ------------------------------------------------------------
  // axi4-lite handshakes
  // ------------------------------------------------------------
  // address and data are caught independently, in either order
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (awvalid && awready_q) begin
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_map && idle) ? RESP_OKAY : RESP_SLV;
      end else if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_map ? RESP_OKAY : RESP_SLV;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign pc      = pc_q;
  assign carry   = flags_q.c;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  wire ex = (state_q == ST_EXEC);

  property p_or;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && ctrl_q.op == OP_OR |=> flags_q.c == ($past(flags_q.c) |
                                               $past(sel_bit));
  endproperty
  a_or: assert property (p_or) else $error("or into carry wrong");

  property p_ixor;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && ctrl_q.op == OP_IXOR |=> flags_q.c == ($past(flags_q.c) ^
                                                 ~$past(sel_bit));
  endproperty
  a_ixor: assert property (p_ixor) else $error("ixor wrong");

  property p_ild;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && ctrl_q.op == OP_ILD |=> flags_q.c == ~$past(sel_bit);
  endproperty
  a_ild: assert property (p_ild) else $error("ild wrong");

  property p_inv_imm;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && op_inv |-> sel_bit == (ctrl_q.to_mem ? tmp_q[ctrl_q.imm]
                                               : opnd_q[ctrl_q.imm]);
  endproperty
  a_inv_imm: assert property (p_inv_imm) else $error("idx src");

  property p_st;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && ctrl_q.op == OP_ST && !ctrl_q.to_mem |=>
      opnd_q[$past(bit_idx)] == flags_q.c && $stable(flags_q.c);
  endproperty
  a_st: assert property (p_st) else $error("store bit wrong");

  property p_keep;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && !op_store |=> $stable(opnd_q) && $stable(tmp_q);
  endproperty
  a_keep: assert property (p_keep) else $error("operand hit");

  property p_rmw;
    @(posedge sys_clk) disable iff (!rst_b)
    state_q == ST_MREAD && op_store ##1 ex |=>
      ((tmp_q ^ $past(tmp_q)) & ~(8'h01 << $past(bit_idx))) == 8'h00
      ##1 mem_q[ctrl_q.maddr] == $past(tmp_q);
  endproperty
  a_rmw: assert property (p_rmw) else $error("rmw wrong");

  property p_cond;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && ctrl_q.op == OP_COND |=>
      pc_q == ($past(cond_true(ctrl_q.cond, flags_q)) ? $past(tgt_q)
                                                      : $past(seq_pc));
  endproperty
  a_cond: assert property (p_cond) else $error("branch pc");

  property p_ret;
    @(posedge sys_clk) disable iff (!rst_b)
    ex && pop_ok |=> pc_q == $past(stk_top) && sp_q == $past(sp_q) - 1;
  endproperty
  a_ret: assert property (p_ret) else $error("return pc");
endmodule

// [test/bcb_unit_tb.sv]
// testbench: bit/carry operations and branch evaluation
`timescale 1ns/1ns
module bcb_unit_tb;
  import bcb_pkg::*;
  // ---------------------------------------------------------
  // signals
  // ---------------------------------------------------------
  logic        sys_clk, rst_b, awvalid, wvalid, bready, arvalid;
  logic        rready, awready, wready, bvalid, arready, rvalid;
  logic        carry;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, pc, rd;    // rd: last read word
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;        // rs: last response
  int          errors, checked;
  bcb_unit bcb_unit_inst (.sys_clk, .rst_b, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pc, .carry);
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------
  // bus tasks; each starts one edge late so no strobe is
  // lowered and raised again in one time step
  // ---------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rs = bresp; bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata; rs = rresp; rready <= 1'h0;
  endtask
  // launch an op and poll busy until it clears
  task automatic go(input logic [31:0] w);
    axw(CTRL_ADDR, w);
    do axr(STAT_ADDR); while (rd[1] !== 1'h0);
  endtask
  function automatic logic [31:0] mk(input logic [3:0] op, cd,
    input logic [2:0] im, input logic rg, mm, l4, input logic [2:0] ma);
    return {15'h0, ma, l4, mm, rg, im, cd, op};
  endfunction
  // expected branch outcome; f is {n,z,v,c}
  function automatic logic ev(input logic [3:0] cc, f);
    logic r;
    case (cc[3:1])
      3'h0: r = 1'h1;
      3'h1: r = ~(f[0] | f[2]);
      3'h2: r = ~f[0];
      3'h3: r = ~f[2];
      3'h4: r = ~f[1];
      3'h5: r = ~f[3];
      3'h6: r = ~(f[3] ^ f[1]);
      default: r = ~(f[2] | (f[3] ^ f[1]));
    endcase
    return r ^ cc[0];
  endfunction
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------
  // gpr index 1 picks a 0, immediates 0/5 pick a 1 in A5
  task automatic t_bits;
    logic [7:0] v;
    logic [2:0] ix;
    logic       inv, x, e;
    v = 8'hA5;
    axw(OPND_ADDR, 32'h0000_00A5);
    axw(GPR_ADDR, 32'h0000_00F9);
    for (int op = 1; op <= 6; op++) begin
      for (int k = 0; k < 4; k++) begin
        inv = (op % 2 == 0);
        ix = k[1] ? 3'h5 : 3'h0;
        if (!inv && !k[1]) ix = 3'h1;
        x = v[ix] ^ inv;
        e = (op < 3) ? (k[0] | x) : (op < 5) ? (k[0] ^ x) : x;
        axw(FLAGS_ADDR, 32'(k[0]));
        go(mk(4'(op), 4'h0, k[1] ? 3'h5 : 3'h0, !k[1], 1'h0, 1'h0, 3'h0));
        chk(32'(carry),
            32'(e));
      end
    end
    axr(OPND_ADDR);
    chk(rd, 32'h0000_00A5);
    chk(32'(rs), 32'(RESP_OKAY));
    $display("bit ops done");
  endtask
  task automatic t_store;
    axw(FLAGS_ADDR, 32'h0);
    go(mk(OP_ST, 4'h0, 3'h2, 1'h0, 1'h0, 1'h0, 3'h0));
    go(mk(OP_IST, 4'h0, 3'h6, 1'h1, 1'h0, 1'h0, 3'h0));
    axr(OPND_ADDR);
    chk(rd, 32'h0000_00E1);
    go(mk(OP_NONE, 4'h0, 3'h0, 1'h0, 1'h0, 1'h0, 3'h3));
    axw(MDATA_ADDR, 32'h0000_005A);
    axw(FLAGS_ADDR, 32'h1);
    go(mk(OP_ST, 4'h0, 3'h0, 1'h0, 1'h1, 1'h0, 3'h3));
    go(mk(OP_IST, 4'h0, 3'h1, 1'h0, 1'h1, 1'h0, 3'h3));
    axr(MDATA_ADDR);
    chk(rd, 32'h0000_0059);
    chk(32'(carry), 32'h1);
    axw(8'h20, 32'h0);
    chk(32'(rs), 32'(RESP_SLV));
    // unaligned read: error response and zero data
    axr(8'h02);
    chk(32'(rs), 32'(RESP_SLV));
    chk(rd, 32'h0000_0000);
    $display("store done");
  endtask
  // every condition against every flag pattern
  task automatic t_cond;
    axw(TGT_ADDR, 32'h0000_0200);
    for (int cc = 0; cc < 16; cc++) begin
      for (int f = 0; f < 16; f++) begin
        axw(FLAGS_ADDR, 32'(f));
        axw(PC_ADDR, 32'h0000_0100);
        go(mk(OP_COND, 4'(cc), 3'h0, 1'h0, 1'h0, 1'(cc), 3'h0));
        chk(pc, ev(4'(cc), 4'(f)) ? 32'h200
            : cc[0] ? 32'h104 : 32'h102);
      end
    end
    $display("branch done");
  endtask
  // nested calls, a jump in between, then unwinding
  task automatic t_flow;
    axw(PC_ADDR, 32'h0000_0040);
    axw(TGT_ADDR, 32'h0000_0300);
    go(mk(OP_CALLD, 4'h0, 3'h0, 1'h0, 1'h0, 1'h0, 3'h0));
    chk(pc, 32'h0000_0300);
    axw(TGT_ADDR, 32'h0000_0500);
    go(mk(OP_CALLE, 4'h0, 3'h0, 1'h0, 1'h0, 1'h1, 3'h0));
    chk(pc, 32'h0000_0500);
    axw(TGT_ADDR, 32'h0000_0080);
    go(mk(OP_JUMP, CC_NEVER, 3'h0, 1'h0, 1'h0, 1'h0, 3'h0));
    chk(pc, 32'h0000_0080);
    go(mk(OP_RET, 4'h0, 3'h0, 1'h0, 1'h0, 1'h0, 3'h0));
    chk(pc, 32'h0000_0304);
    go(mk(OP_RET, 4'h0, 3'h0, 1'h0, 1'h0, 1'h0, 3'h0));
    chk(pc, 32'h0000_0042);
    // return on an empty stack falls through and sets the error
    go(mk(OP_RET, 4'h0, 3'h0, 1'h0, 1'h0, 1'h0, 3'h0));
    chk(pc, 32'h0000_0044);
    axr(STAT_ADDR);
    chk(rd, 32'h0000_0008);
    $display("flow done");
  endtask
  // ---------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    errors = 0;
    checked = 0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_bits;
    t_store;
    t_cond;
    t_flow;
    conclude;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    conclude;
  end
endmodule
